// file: design/pwmf_top.sv
// Register file, flags, fault shutdown and pin steering of the PWM block
// Function
// - Move instructions: RAM if bit 0, registers if 1
// - Counter zero starts conversion when both enables set
// - Initial level bit sets idle output level
// - Generator runs only while global enable set
// - Output enable hands pins to PWM, else GPIO
// - Counter zero sets sticky flag, optional interrupt
// - Selected compare match sets sticky channel flag
// - Fault detection active only when enabled
// - Float bit puts enabled PWM pins high impedance while fault flag set
// - Fault interrupt only when its enable set
// - Comparator fault when comparator output high
// - Pin fault when fault pin high
// - Fault sets sticky flag, optional interrupt
// - Pin select chooses first or second pin group
// - Channel interrupt requested while flag and enable
// - Second match sets flag when selected
// - First match sets flag when selected
// - Unselected match raises no channel event
// - All channels share one 15-bit counter
// - Two compare values per channel toggle output
// - Fault forces emergency PWM shutdown
`timescale 1ns/1ps
module pwmf_top import pwmf_pkg::*; #(
    parameter int CW = CNT_W,
    parameter int DIV = DIV_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire pwmf_bus_t bus,
    input wire logic [CW-1:0] period,
    input wire logic [NUM_CH-1:0][CW-1:0] cmp_first,
    input wire logic [NUM_CH-1:0][CW-1:0] cmp_second,
    input wire logic [NUM_CH-3:0][3:0] upper_ch_ctl,
    input wire logic converter_enable,
    input wire logic cmp_fault_in,
    input wire logic fault_pin_in,
    output logic [7:0] rdata,
    output pwmf_auxiliary_ram_t auxiliary_ram,
    output pwmf_pins_t pins,
    output logic adc_start,
    output logic pwm_irq,
    output logic fault_irq
);
    typedef struct packed {
        logic [7:0] psw2;
        logic [7:0] cfg;
        logic [7:0] ctrl;
        logic [7:0] iflag;
        logic [7:0] fdcr;
        logic [3:0] ccr2;
        logic [3:0] ccr3;
        logic [7:0] rdata;
        pwmf_auxiliary_ram_t auxiliary_ram;
        pwmf_pins_t pins;
        logic adc_start;
        logic pwm_irq;
        logic fault_irq;
        logic cmp_meta;
        logic cmp_sync;
        logic pin_meta;
        logic pin_sync;
    } pwmf_top_st_t;

    pwmf_top_st_t s_q, s_d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [CW-1:0] cnt;
    logic step;
    logic zero_evt;
    logic fault_hit;
    logic ext_sel;
    logic [NUM_CH-1:0] ch_level;
    logic [NUM_CH-1:0] ch_evt;
    logic [NUM_CH-1:0][3:0] ch_ctl;
    logic [NUM_CH-1:0] ch_ie;

    if (NUM_CH != 6 || CW != 15) begin : g_bad_param
        $error("pwmf_top supports six channels on a 15-bit counter only");
    end

    // Reset release through two flip-flops
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Shared time base, stopped while generator is off
    pwmf_counter #(.CW(CW), .DIV(DIV)) u_counter (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .en(s_q.ctrl[CTRL_GEN]),
        .period(period),
        .cnt(cnt),
        .step(step)
    );

    assign zero_evt = step && (cnt == '0);

    // Per channel control: two local registers, rest from outside
    always_comb begin
        ch_ctl = '0;
        ch_ctl[0] = s_q.ccr2;
        ch_ctl[1] = s_q.ccr3;
        for (int i = 2; i < NUM_CH; i++) begin
            ch_ctl[i] = upper_ch_ctl[i-2];
        end
    end

    // Six channels on the common counter
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        assign ch_ie[g] = ch_ctl[g][CCR_IE];
        pwmf_channel #(.CW(CW)) u_ch (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .en(s_q.ctrl[CTRL_GEN]),
            .init(s_q.cfg[g]),
            .cnt(cnt),
            .step(step),
            .cmp_a(cmp_first[g]),
            .cmp_b(cmp_second[g]),
            .sel_a(ch_ctl[g][CCR_SELA]),
            .sel_b(ch_ctl[g][CCR_SELB]),
            .level(ch_level[g]),
            .evt(ch_evt[g])
        );
    end

    // Fault sources after synchronisers, gated by detect enable
    assign fault_hit = s_q.fdcr[FD_EN] &&
        ((s_q.fdcr[FD_CMP] && s_q.cmp_sync) ||
        (s_q.fdcr[FD_PIN] && s_q.pin_sync));

    // Extended space select for move instructions
    assign ext_sel = s_q.psw2[PSW2_EXT];

    // Next state: bus writes, hardware sets, reads and pin steering
    always_comb begin
        s_d = s_q;
        s_d.cmp_meta = cmp_fault_in;
        s_d.cmp_sync = s_q.cmp_meta;
        s_d.pin_meta = fault_pin_in;
        s_d.pin_sync = s_q.pin_meta;

        // Direct register writes
        if (bus.sfr_wr) begin
            case (bus.sfr_addr)
                ADDR_PSW2: s_d.psw2 = bus.wdata;
                ADDR_CFG: s_d.cfg = bus.wdata & MASK_CFG;
                ADDR_CTRL: s_d.ctrl = bus.wdata;
                ADDR_IFLAG: s_d.iflag = bus.wdata & MASK_IFLAG;
                ADDR_FDCR: s_d.fdcr = bus.wdata & MASK_FDCR;
                default: ;
            endcase
        end

        // Extended register writes only with access bit set
        if (bus.movx_wr && ext_sel) begin
            case (bus.movx_addr)
                XADDR_CH2: s_d.ccr2 = bus.wdata[3:0];
                XADDR_CH3: s_d.ccr3 = bus.wdata[3:0];
                default: ;
            endcase
        end

        // Hardware sets after software writes so sets win
        s_d.iflag[IF_ZERO] = s_d.iflag[IF_ZERO] | zero_evt;
        s_d.iflag[NUM_CH-1:0] = s_d.iflag[NUM_CH-1:0] | ch_evt;
        if (fault_hit) begin
            s_d.fdcr[FD_FLAG] = 1'b1;
            s_d.ctrl[CTRL_GEN] = 1'b0;
        end

        // Read data, reserved bits zero
        s_d.rdata = 8'h00;
        if (bus.sfr_rd) begin
            case (bus.sfr_addr)
                ADDR_PSW2: s_d.rdata = s_q.psw2;
                ADDR_CFG: s_d.rdata = s_q.cfg;
                ADDR_CTRL: s_d.rdata = s_q.ctrl;
                ADDR_IFLAG: s_d.rdata = s_q.iflag;
                ADDR_FDCR: s_d.rdata = s_q.fdcr;
                default: s_d.rdata = 8'h00;
            endcase
        end else if (bus.movx_rd && ext_sel) begin
            case (bus.movx_addr)
                XADDR_CH2: s_d.rdata = {4'h0, s_q.ccr2};
                XADDR_CH3: s_d.rdata = {4'h0, s_q.ccr3};
                default: s_d.rdata = 8'h00;
            endcase
        end

        // Moves with access bit clear go to auxiliary RAM
        s_d.auxiliary_ram.wr = bus.movx_wr && !ext_sel;
        s_d.auxiliary_ram.rd = bus.movx_rd && !ext_sel;
        s_d.auxiliary_ram.addr = bus.movx_addr;
        s_d.auxiliary_ram.wdata = bus.wdata;

        // Pin ownership, group select and fault float
        for (int i = 0; i < NUM_CH; i++) begin
            s_d.pins.own_a[i] = s_q.ctrl[i] && !ch_ctl[i][CCR_PS];
            s_d.pins.own_b[i] = s_q.ctrl[i] && ch_ctl[i][CCR_PS];
        end
        s_d.pins.level = ch_level;
        s_d.pins.hiz = {NUM_CH{s_q.fdcr[FD_FLOAT] && s_q.fdcr[FD_FLAG]}} &
            s_q.ctrl[NUM_CH-1:0];

        // Conversion start on counter zero
        s_d.adc_start = zero_evt && s_q.cfg[CFG_ADC] && s_q.ctrl[CTRL_GEN] &&
            converter_enable;

        // Interrupt requests from the updated flags
        s_d.pwm_irq = (s_d.iflag[IF_ZERO] && s_d.ctrl[CTRL_ZIE]) ||
            |(s_d.iflag[NUM_CH-1:0] & ch_ie);
        s_d.fault_irq = s_d.fdcr[FD_FLAG] && s_d.fdcr[FD_IE];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign rdata = s_q.rdata;
    assign auxiliary_ram = s_q.auxiliary_ram;
    assign pins = s_q.pins;
    assign adc_start = s_q.adc_start;
    assign pwm_irq = s_q.pwm_irq;
    assign fault_irq = s_q.fault_irq;

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_ram_route;
        bus.movx_wr && !ext_sel |=> auxiliary_ram.wr && auxiliary_ram.addr == $past(bus.movx_addr);
    endproperty
    a_ram_route: assert property (p_ram_route) else $error("move lost to RAM");

    property p_reg_route;
        bus.movx_wr && ext_sel && bus.movx_addr == XADDR_CH2 |=>
            !auxiliary_ram.wr && s_q.ccr2 == $past(bus.wdata[3:0]);
    endproperty
    a_reg_route: assert property (p_reg_route) else $error("extended write misrouted");

    property p_adc;
        adc_start |-> $past(zero_evt && s_q.cfg[CFG_ADC] && converter_enable);
    endproperty
    a_adc: assert property (p_adc) else $error("conversion start without cause");

    property p_init;
        (!s_q.ctrl[CTRL_GEN] && $stable(s_q.cfg)) [*3] |-> pins.level == s_q.cfg[5:0];
    endproperty
    a_init: assert property (p_init) else $error("idle level wrong");

    property p_gen_off;
        !s_q.ctrl[CTRL_GEN] |=> !step ##0 cnt == '0;
    endproperty
    a_gen_off: assert property (p_gen_off) else $error("counter runs while off");

    property p_zero_flag;
        zero_evt |=> s_q.iflag[IF_ZERO] && (pwm_irq || !s_q.ctrl[CTRL_ZIE]);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag lost");

    property p_ch_flag;
        |ch_evt |=> (s_q.iflag[5:0] & $past(ch_evt)) == $past(ch_evt);
    endproperty
    a_ch_flag: assert property (p_ch_flag) else $error("channel flag lost");

    property p_fault_off;
        !s_q.fdcr[FD_EN] && !(bus.sfr_wr && bus.sfr_addr == ADDR_FDCR) |=>
            s_q.fdcr[FD_FLAG] == $past(s_q.fdcr[FD_FLAG]);
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("fault while disabled");

    property p_shutdown;
        fault_hit |=> !s_q.ctrl[CTRL_GEN] && s_q.fdcr[FD_FLAG] ##1
            (pins.hiz == '0 || s_q.fdcr[FD_FLOAT]);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("fault did not shut down");

    property p_fault_irq;
        fault_irq |-> $past(s_d.fdcr[FD_IE]);
    endproperty
    a_fault_irq: assert property (p_fault_irq) else $error("fault irq while masked");

    property p_sel_flag;
        step && ((cnt == cmp_first[0] && ch_ctl[0][CCR_SELA]) ||
            (cnt == cmp_second[0] && ch_ctl[0][CCR_SELB])) |=> s_q.iflag[0];
    endproperty
    a_sel_flag: assert property (p_sel_flag) else $error("selected match lost");

    property p_no_sel;
        !ch_ctl[1][CCR_SELA] && !ch_ctl[1][CCR_SELB] && !s_q.iflag[1] &&
            !(bus.sfr_wr && bus.sfr_addr == ADDR_IFLAG) |=> !s_q.iflag[1];
    endproperty
    a_no_sel: assert property (p_no_sel) else $error("unselected match set flag");

    property p_toggle;
        s_q.ctrl[CTRL_GEN] && step && (cnt == cmp_first[1] || cnt == cmp_second[1]) |->
            ##2 (pins.level[1] != $past(pins.level[1]));
    endproperty
    a_toggle: assert property (p_toggle) else $error("match did not toggle");

    property p_ch_irq;
        s_q.iflag[0] && ch_ie[0] && !bus.sfr_wr && !bus.movx_wr |=> pwm_irq;
    endproperty
    a_ch_irq: assert property (p_ch_irq) else $error("channel irq missing");

    property p_own_off;
        !s_q.ctrl[0] |=> !pins.own_a[0] && !pins.own_b[0];
    endproperty
    a_own_off: assert property (p_own_off) else $error("disabled channel drives pin");

    property p_group;
        s_q.ctrl[0] && ch_ctl[0][CCR_PS] |=> pins.own_b[0] && !pins.own_a[0];
    endproperty
    a_group: assert property (p_group) else $error("wrong pin group");

    property p_float;
        s_q.fdcr[FD_FLAG] && s_q.ctrl[0] |=> pins.hiz[0] == $past(s_q.fdcr[FD_FLOAT]);
    endproperty
    a_float: assert property (p_float) else $error("float mode wrong");

    property p_pin_fault;
        s_q.fdcr[FD_EN] && s_q.fdcr[FD_PIN] && s_q.pin_sync |=> s_q.fdcr[FD_FLAG];
    endproperty
    a_pin_fault: assert property (p_pin_fault) else $error("pin fault missed");

    property p_cmp_fault;
        s_q.fdcr[FD_EN] && s_q.fdcr[FD_CMP] && s_q.cmp_sync |=> s_q.fdcr[FD_FLAG];
    endproperty
    a_cmp_fault: assert property (p_cmp_fault) else $error("comparator fault missed");

    c_zero_adc: cover property (adc_start);
    c_fault: cover property (fault_hit ##1 fault_irq);
    c_ch_irq: cover property (|ch_evt ##[1:2] pwm_irq);
    c_float: cover property (pins.hiz[0]);
endmodule // pwmf_top

// file: include/pwmf_pkg.sv
// Shared constants and carrier types of the six channel PWM fault block
package pwmf_pkg;
    // Channel count and shared counter width
    localparam int NUM_CH = 6;
    localparam int CNT_W = 15;
    localparam int DIV_DEFAULT = 1;

    // Special function register addresses
    localparam logic [7:0] ADDR_PSW2 = 8'hBA;
    localparam logic [7:0] ADDR_CFG = 8'hF1;
    localparam logic [7:0] ADDR_CTRL = 8'hF5;
    localparam logic [7:0] ADDR_IFLAG = 8'hF6;
    localparam logic [7:0] ADDR_FDCR = 8'hF7;

    // Extended register space addresses
    localparam logic [15:0] XADDR_CH2 = 16'hFF04;
    localparam logic [15:0] XADDR_CH3 = 16'hFF14;

    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [3:0] RST_CCR = 4'h0;

    // Implemented bit masks, reserved bits read zero
    localparam logic [7:0] MASK_CFG = 8'h7F;
    localparam logic [7:0] MASK_IFLAG = 8'h7F;
    localparam logic [7:0] MASK_FDCR = 8'h3F;
    localparam logic [7:0] MASK_CCR = 8'h0F;

    // Field positions
    localparam int PSW2_EXT = 7;
    localparam int CFG_ADC = 6;
    localparam int CTRL_GEN = 7;
    localparam int CTRL_ZIE = 6;
    localparam int IF_ZERO = 6;
    localparam int FD_EN = 5;
    localparam int FD_FLOAT = 4;
    localparam int FD_IE = 3;
    localparam int FD_CMP = 2;
    localparam int FD_PIN = 1;
    localparam int FD_FLAG = 0;
    localparam int CCR_PS = 3;
    localparam int CCR_IE = 2;
    localparam int CCR_SELB = 1;
    localparam int CCR_SELA = 0;

    // Core access request
    typedef struct packed {
        logic sfr_wr;
        logic sfr_rd;
        logic [7:0] sfr_addr;
        logic movx_wr;
        logic movx_rd;
        logic [15:0] movx_addr;
        logic [7:0] wdata;
    } pwmf_bus_t;

    // Move forwarded to auxiliary RAM
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } pwmf_auxiliary_ram_t;

    // Pin drive of the six channels, index 0 is channel 2
    typedef struct packed {
        logic [NUM_CH-1:0] level;
        logic [NUM_CH-1:0] own_a;
        logic [NUM_CH-1:0] own_b;
        logic [NUM_CH-1:0] hiz;
    } pwmf_pins_t;
endpackage

// file: design/pwmf_counter.sv
// Shared time base: prescale divider and counter with wrap at period
`timescale 1ns/1ps
module pwmf_counter import pwmf_pkg::*; #(
    parameter int CW = CNT_W,
    parameter int DIV = DIV_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic en,
    input wire logic [CW-1:0] period,
    output logic [CW-1:0] cnt,
    output logic step
);
    typedef struct packed {
        logic [15:0] div;
        logic [CW-1:0] cnt;
        logic step;
    } pwmf_cnt_st_t;

    pwmf_cnt_st_t s_q, s_d;

    if (DIV < 1 || DIV > 65536 || CW < 2) begin : g_bad_param
        $error("pwmf_counter parameters out of range");
    end

    // Divider tick, then counter advance; held at zero while off
    always_comb begin
        s_d = s_q;
        s_d.step = 1'b0;
        if (!en) begin
            s_d.div = 16'h0000;
            s_d.cnt = '0;
        end else if (s_q.div == 16'(DIV - 1)) begin
            s_d.div = 16'h0000;
            s_d.step = 1'b1;
            s_d.cnt = (s_q.cnt == period) ? '0 : CW'(s_q.cnt + 1'b1);
        end else begin
            s_d.div = 16'(s_q.div + 1'b1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cnt = s_q.cnt;
    assign step = s_q.step;
endmodule // pwmf_counter

// file: design/pwmf_channel.sv
// One PWM channel: toggles on either compare match, reports flag events
`timescale 1ns/1ps
module pwmf_channel import pwmf_pkg::*; #(
    parameter int CW = CNT_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic en,
    input wire logic init,
    input wire logic [CW-1:0] cnt,
    input wire logic step,
    input wire logic [CW-1:0] cmp_a,
    input wire logic [CW-1:0] cmp_b,
    input wire logic sel_a,
    input wire logic sel_b,
    output logic level,
    output logic evt
);
    typedef struct packed {
        logic level;
    } pwmf_ch_st_t;

    pwmf_ch_st_t s_q, s_d;
    logic hit_a;
    logic hit_b;

    // Matches count only on a fresh counter value
    assign hit_a = step && (cnt == cmp_a);
    assign hit_b = step && (cnt == cmp_b);
    assign evt = (hit_a && sel_a) || (hit_b && sel_b);

    // Idle at initial level, toggle on any match
    always_comb begin
        s_d = s_q;
        if (!en) begin
            s_d.level = init;
        end else if (hit_a || hit_b) begin
            s_d.level = ~s_q.level;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.level;
endmodule // pwmf_channel

// file: verif/pwmf_core_model.sv
// Processor core model issuing register and move accesses to the PWM block
`timescale 1ns/1ps
module pwmf_core_model import pwmf_pkg::*; (
    input wire logic clk_sys,
    input wire logic [7:0] rdata,
    output pwmf_bus_t bus
);
    // Bus idle at time zero
    initial begin
        bus <= '0;
    end

    // One access: strobe for one edge, then released lines stop showing the old values
    task automatic access(input logic mv, input logic wr, input logic [15:0] a,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys);
        bus <= {!mv && wr, !mv && !wr, a[7:0], mv && wr, mv && !wr, a, d};
        @(posedge clk_sys);
        bus <= {2'b00, ~a[7:0], 2'b00, ~a, ~d};
        #1 q = rdata;
    endtask
endmodule // pwmf_core_model

// file: verif/six_channel_pwm_fault_ctrl_test.sv
// Self-checking testbench of the PWM register, flag and fault block
`timescale 1ns/1ps
module six_channel_pwm_fault_ctrl_test import pwmf_pkg::*; ;
    logic clk_sys = 1'b0;
    logic nrst;
    pwmf_bus_t bus;
    logic [CNT_W-1:0] period;
    logic [NUM_CH-1:0][CNT_W-1:0] cmp_first;
    logic [NUM_CH-1:0][CNT_W-1:0] cmp_second;
    logic [NUM_CH-3:0][3:0] upper_ch_ctl;
    logic converter_enable;
    logic cmp_fault_in;
    logic fault_pin_in;
    logic [7:0] rdata;
    pwmf_auxiliary_ram_t auxiliary_ram;
    pwmf_pins_t pins;
    logic adc_start;
    logic pwm_irq;
    logic fault_irq;
    int err_count = 0;
    int total_checks = 0;
    int tog0;
    int tog1;
    int adc_n;
    int run_tog0 = 0;
    int run_tog1 = 0;
    int run_adc = 0;
    logic [1:0] lvl_prev;

    // 125 MHz system clock
    always #4 clk_sys = ~clk_sys;

    pwmf_top i_pwmf_top (.clk_sys(clk_sys), .nrst(nrst), .bus(bus), .period(period),
        .cmp_first(cmp_first), .cmp_second(cmp_second), .upper_ch_ctl(upper_ch_ctl),
        .converter_enable(converter_enable), .cmp_fault_in(cmp_fault_in),
        .fault_pin_in(fault_pin_in), .rdata(rdata), .auxiliary_ram(auxiliary_ram), .pins(pins),
        .adc_start(adc_start), .pwm_irq(pwm_irq), .fault_irq(fault_irq));

    pwmf_core_model i_pwmf_core_model (.clk_sys(clk_sys), .rdata(rdata), .bus(bus));

    // Toggle and conversion start counters
    always @(posedge clk_sys) begin
        lvl_prev <= pins.level[1:0];
        if (pins.level[0] !== lvl_prev[0]) run_tog0++;
        if (pins.level[1] !== lvl_prev[1]) run_tog1++;
        if (adc_start === 1'b1) run_adc++;
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Addresses above 0xFF go out as moves
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] r;
        i_pwmf_core_model.access(a[15:8] != 8'h00, 1'b1, a, d, r);
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [7:0] e, input string name);
        logic [7:0] r;
        i_pwmf_core_model.access(a[15:8] != 8'h00, 1'b0, a, 8'h00, r);
        chk(name, 16'(e), 16'(r));
    endtask

    // Count over a window of whole counter periods
    task automatic win(input int n);
        int b0;
        int b1;
        int b2;
        #1;
        b0 = run_tog0;
        b1 = run_tog1;
        b2 = run_adc;
        repeat (n) @(posedge clk_sys);
        #1;
        tog0 = run_tog0 - b0;
        tog1 = run_tog1 - b1;
        adc_n = run_adc - b2;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog sized well above the test run
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        $display("BAD watchdog expired");
        report_and_stop();
    end

    // Main sequence
    initial begin
        nrst = 1'b0;
        period = 15'h0009;
        cmp_first = '0;
        cmp_second = '0;
        upper_ch_ctl = '0;
        converter_enable = 1'b0;
        cmp_fault_in = 1'b0;
        fault_pin_in = 1'b0;
        cmp_first[0] = 15'h0003;
        cmp_second[0] = 15'h0006;
        cmp_first[1] = 15'h0002;
        cmp_second[1] = 15'h0002;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        // Reset values, unmapped address, reserved bits and flag writes
        rdchk(16'h00BA, 8'h00, "switch reset");
        rdchk(16'h00F1, 8'h00, "config reset");
        rdchk(16'h00F5, 8'h00, "control reset");
        rdchk(16'h00F6, 8'h00, "flags reset");
        rdchk(16'h00F7, 8'h00, "fault reset");
        rdchk(16'h00F0, 8'h00, "unmapped read");
        wr(16'h00F1, 8'hFF);
        rdchk(16'h00F1, 8'h7F, "config mask");
        wr(16'h00F1, 8'h00);
        wr(16'h00F7, 8'h09);
        chk("fault irq on", 16'h0001, 16'(fault_irq));
        wr(16'h00F7, 8'h08);
        chk("fault flag clear", 16'h0000, 16'(fault_irq));
        wr(16'h00F7, 8'h01);
        chk("fault irq masked", 16'h0000, 16'(fault_irq));
        wr(16'h00F7, 8'h00);
        $display("test registers done");
        // Moves go to RAM until the access bit is set
        wr(16'hFF04, 8'h5A);
        chk("ram write", 16'h0001, 16'(auxiliary_ram.wr));
        chk("ram addr", 16'hFF04, auxiliary_ram.addr);
        chk("ram data", 16'h005A, 16'(auxiliary_ram.wdata));
        rdchk(16'hFF04, 8'h00, "ram read data");
        chk("ram read", 16'h0001, 16'(auxiliary_ram.rd));
        wr(16'h00BA, 8'h80);
        wr(16'hFF04, 8'hFF);
        chk("ram quiet", 16'h0000, 16'(auxiliary_ram.wr));
        rdchk(16'hFF04, 8'h0F, "ch2 ctl mask");
        rdchk(16'h00BA, 8'h80, "switch rw");
        wr(16'hFF04, 8'h05);
        $display("test moves done");
        // Running: ch2 flags on first match, ch3 equal matches and no select
        @(posedge clk_sys);
        converter_enable <= 1'b1;
        wr(16'h00F1, 8'h40);
        wr(16'h00F5, 8'h83);
        repeat (20) @(posedge clk_sys);
        win(100);
        chk("ch2 toggles", 16'd20, 16'(tog0));
        chk("ch3 toggles", 16'd10, 16'(tog1));
        chk("adc starts", 16'd10, 16'(adc_n));
        chk("group a", 16'h0001, 16'(pins.own_a[0]));
        chk("irq ch2", 16'h0001, 16'(pwm_irq));
        rdchk(16'h00F6, 8'h41, "run flags");
        wr(16'hFF04, 8'h0E);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("group b", 16'h0001, 16'(pins.own_b[0]));
        chk("group a off", 16'h0000, 16'(pins.own_a[0]));
        @(posedge clk_sys);
        converter_enable <= 1'b0;
        @(posedge clk_sys);
        win(100);
        chk("adc gated", 16'd0, 16'(adc_n));
        wr(16'h00F5, 8'h03);
        wr(16'h00F6, 8'h00);
        rdchk(16'h00F6, 8'h00, "flags cleared");
        chk("irq idle", 16'h0000, 16'(pwm_irq));
        wr(16'h00F1, 8'h03);
        repeat (4) @(posedge clk_sys);
        win(50);
        chk("init levels", 16'h0003, 16'(pins.level[1:0]));
        chk("stopped", 16'd0, 16'(tog0));
        wr(16'h00F6, 8'h40);
        chk("zero irq masked", 16'h0000, 16'(pwm_irq));
        wr(16'h00F5, 8'h43);
        chk("zero irq", 16'h0001, 16'(pwm_irq));
        wr(16'h00F5, 8'h03);
        wr(16'h00F6, 8'h01);
        chk("ch2 irq", 16'h0001, 16'(pwm_irq));
        wr(16'hFF04, 8'h08);
        @(posedge clk_sys);
        #1;
        chk("ch2 irq masked", 16'h0000, 16'(pwm_irq));
        wr(16'h00F6, 8'h00);
        $display("test channels done");
        // Fault sources, float and shutdown
        wr(16'h00F5, 8'h81);
        wr(16'h00F7, 8'h3A);
        @(posedge clk_sys);
        cmp_fault_in <= 1'b1;
        repeat (10) @(posedge clk_sys);
        #1;
        chk("cmp ignored", 16'h0000, 16'(fault_irq));
        @(posedge clk_sys);
        fault_pin_in <= 1'b1;
        repeat (10) @(posedge clk_sys);
        #1;
        chk("pin fault irq", 16'h0001, 16'(fault_irq));
        chk("float", 16'h0001, 16'(pins.hiz[0]));
        rdchk(16'h00F5, 8'h01, "shutdown");
        rdchk(16'h00F7, 8'h3B, "fault flag");
        @(posedge clk_sys);
        fault_pin_in <= 1'b0;
        repeat (5) @(posedge clk_sys);
        wr(16'h00F7, 8'h3A);
        @(posedge clk_sys);
        #1;
        chk("float released", 16'h0000, 16'(pins.hiz[0]));
        wr(16'h00F7, 8'h2C);
        repeat (10) @(posedge clk_sys);
        #1;
        chk("cmp fault irq", 16'h0001, 16'(fault_irq));
        chk("no float", 16'h0000, 16'(pins.hiz[0]));
        wr(16'h00F7, 8'h0C);
        rdchk(16'h00F7, 8'h0D, "set beats clear");
        wr(16'h00F7, 8'h0C);
        repeat (10) @(posedge clk_sys);
        rdchk(16'h00F7, 8'h0C, "detect off");
        chk("detect off irq", 16'h0000, 16'(fault_irq));
        $display("test faults done");
        report_and_stop();
    end
endmodule // six_channel_pwm_fault_ctrl_test
